//--- hw/paired_timer_32bit.sv
// Two timer pairs, each two 16-bit timers or one 32-bit timer.
// Functional notes
// - Each pair works as one 32-bit timer or two 16-bit timers.
// - A joined pair is one 32-bit timer or synchronous counter.
// - Split timers keep all 16-bit modes except asynchronous counting.
// - Every 16-bit timer alone is a synchronous timer or counter.
// - Even timer holds the low word, odd timer the high word.
// - When joined, the odd control register is ignored.
// - Joined pair counts from even clock input, gated by even gate.
// - Joined pair flags its match through the odd timer's flag.
// - The 32-bit count is compared with a 32-bit period value.
// - Gated counting, prescaler, and counting through idle or sleep.
// - Only pair A timers feed the capture time base.
// - ADC trigger from joined pairs, else only from odd timers.
// - All four timers can request a DMA transfer.
`timescale 1ns/100ps
`include "paired_timer_map.svh"
module paired_timer_32bit (
  input wire logic clock,
  input wire logic arst_n,
  input wire paired_timer_pkg::word_t timer_a_low_control,
  input wire paired_timer_pkg::word_t timer_a_high_control,
  input wire paired_timer_pkg::word_t timer_b_low_control,
  input wire paired_timer_pkg::word_t timer_b_high_control,
  input wire logic [3:0] period_load,
  input wire paired_timer_pkg::word_t period_data,
  input wire logic [3:0] ext_clk,
  input wire logic [3:0] gate_in,
  output paired_timer_pkg::word_t count_0,
  output paired_timer_pkg::word_t count_1,
  output paired_timer_pkg::word_t count_2,
  output paired_timer_pkg::word_t count_3,
  output logic [3:0] match_flag,
  output logic [3:0] dma_request,
  output logic [1:0] capture_timebase_tick,
  output logic adc_trigger
);
  import paired_timer_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0][15:0] cnt;
    logic [3:0][15:0] pr;
    logic [3:0] match;
    logic [3:0] dma;
    logic [1:0] tb;
    logic adc;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [3:0] tick;
  logic [3:0][15:0] ctl;

  assign ctl[0] = timer_a_low_control;
  assign ctl[1] = timer_a_high_control;
  assign ctl[2] = timer_b_low_control;
  assign ctl[3] = timer_b_high_control;

  // ---------------------------------------------------------------
  // Tick generators
  // ---------------------------------------------------------------
  // The gate, prescaler and source run off this clock only, so counting
  // continues whatever the core's idle or sleep state.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_tick
      timer_tick u_tick (
        .clock(clock),
        .arst_n(arst_n),
        .control(ctl[g]),
        .ext_clk(ext_clk[g]),
        .gate_in(gate_in[g]),
        .tick(tick[g])
      );
    end
  endgenerate

  function automatic logic joined(input logic [15:0] c);
    return c[`CTL_PAIR_BIT];
  endfunction

  // ---------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------
  logic [31:0] c32;
  logic [31:0] p32;
  logic [3:0] hit;
  always_comb begin
    s_next = s_reg;
    hit = 4'h0;
    c32 = 32'h0;
    p32 = 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (period_load[i]) begin
        s_next.pr[i] = period_data;
      end
    end
    for (int p = 0; p < 2; p++) begin
      if (joined(ctl[2*p])) begin
        // Even control, clock and gate drive the whole pair.
        c32 = {s_reg.cnt[2*p+1], s_reg.cnt[2*p]};
        p32 = {s_reg.pr[2*p+1], s_reg.pr[2*p]};
        if (tick[2*p]) begin
          if (c32 == p32) begin
            c32 = 32'h0;
            hit[2*p+1] = 1'b1;
          end else begin
            c32 = c32 + 32'h1;
          end
          s_next.cnt[2*p] = c32[15:0];
          s_next.cnt[2*p+1] = c32[31:16];
        end
      end else begin
        for (int k = 0; k < 2; k++) begin
          if (tick[2*p+k]) begin
            if (s_reg.cnt[2*p+k] == s_reg.pr[2*p+k]) begin
              s_next.cnt[2*p+k] = 16'h0;
              hit[2*p+k] = 1'b1;
            end else begin
              s_next.cnt[2*p+k] = s_reg.cnt[2*p+k] + 16'h1;
            end
          end
        end
      end
    end
    s_next.match = hit;
    s_next.dma = hit;
    s_next.tb = hit[1:0];
    s_next.adc = hit[1] | hit[3];
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        s_reg.cnt[i] <= `CNT_RESET;
        s_reg.pr[i] <= `PR_RESET;
      end
      s_reg.match <= 4'h0;
      s_reg.dma <= 4'h0;
      s_reg.tb <= 2'h0;
      s_reg.adc <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign count_0 = s_reg.cnt[0];
  assign count_1 = s_reg.cnt[1];
  assign count_2 = s_reg.cnt[2];
  assign count_3 = s_reg.cnt[3];
  assign match_flag = s_reg.match;
  assign dma_request = s_reg.dma;
  assign capture_timebase_tick = s_reg.tb;
  assign adc_trigger = s_reg.adc;
endmodule

//--- hw/paired_timer_map.svh
// Constant map for the paired timer block.
`ifndef PAIRED_TIMER_MAP_SVH
`define PAIRED_TIMER_MAP_SVH
`define CTL_ON_BIT 15
`define CTL_GATE_BIT 6
`define CTL_PS_MSB 5
`define CTL_PS_LSB 4
`define CTL_PAIR_BIT 3
`define CTL_SRC_BIT 1
`define CTL_RESET 16'h0000
`define CNT_RESET 16'h0000
`define PR_RESET 16'hffff
`endif

//--- hw/paired_timer_pkg.sv
// Types shared by the paired timer block.
package paired_timer_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {
    ps_div1,
    ps_div8,
    ps_div64,
    ps_div256
  } prescale_t;
  typedef struct packed {
    logic [7:0] div;
    logic clk_last;
    logic gate_last;
  } tick_state_t;
endpackage

//--- hw/timer_tick.sv
// Count-enable generator: clock source, gate and prescaler of one timer.
`timescale 1ns/100ps
`include "paired_timer_map.svh"
module timer_tick (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [15:0] control,
  input wire logic ext_clk,
  input wire logic gate_in,
  output logic tick
);
  import paired_timer_pkg::*;
  tick_state_t st_reg;
  tick_state_t st_next;
  logic raw;
  logic [7:0] lim;
  always_comb begin
    st_next = st_reg;
    st_next.clk_last = ext_clk;
    st_next.gate_last = gate_in;
    unique case (prescale_t'(control[`CTL_PS_MSB:`CTL_PS_LSB]))
      ps_div1: lim = 8'h00;
      ps_div8: lim = 8'h07;
      ps_div64: lim = 8'h3f;
      ps_div256: lim = 8'hff;
    endcase
    if (control[`CTL_SRC_BIT]) begin
      raw = ext_clk && !st_reg.clk_last;
    end else if (control[`CTL_GATE_BIT]) begin
      raw = st_reg.gate_last;
    end else begin
      raw = 1'b1;
    end
    tick = 1'b0;
    if (!control[`CTL_ON_BIT]) begin
      st_next.div = 8'h00;
    end else if (raw) begin
      if (st_reg.div >= lim) begin
        st_next.div = 8'h00;
        tick = 1'b1;
      end else begin
        st_next.div = st_reg.div + 8'h01;
      end
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

//--- verification/ext_pulser.sv
// External count source on the far side.
`timescale 1ns/100ps
module ext_pulser (
  input wire logic clock,
  input wire logic en,
  output logic pulse
);
  always_ff @(posedge clock) begin
    pulse <= en & ~pulse;
  end
endmodule

//--- verification/paired_timer_properties.sv
// Port checker for the paired timer block.
`timescale 1ns/100ps
module paired_timer_properties
  import paired_timer_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire word_t timer_a_low_control,
  input wire word_t timer_b_low_control,
  input wire word_t count_0,
  input wire word_t count_1,
  input wire logic [3:0] match_flag,
  input wire logic [3:0] dma_request,
  input wire logic [1:0] capture_timebase_tick,
  input wire logic adc_trigger
);
  // ---------------------------
  // Assertions
  // ---------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_dma_follows: assert property (dma_request == match_flag)
    else $error("dma request differs from match");
  a_capture_pair_a: assert property
    (capture_timebase_tick == match_flag[1:0])
    else $error("capture tick differs from pair a match");
  a_adc_odd_only: assert property
    (adc_trigger == (match_flag[1] | match_flag[3]))
    else $error("adc trigger wrong");
  a_joined_even_quiet: assert property
    ($past(timer_a_low_control[3]) |-> !match_flag[0])
    else $error("joined even timer pulsed");
  a_joined_b_quiet: assert property
    ($past(timer_b_low_control[3]) |-> !match_flag[2])
    else $error("joined pair b even timer pulsed");
  a_wrap_low: assert property
    (match_flag[0] |-> count_0 == 16'h0000)
    else $error("low count not zero at match");
  a_wrap_high: assert property
    (match_flag[1] |-> count_1 == 16'h0000)
    else $error("high count not zero at match");
  a_step_one: assert property
    (!$stable(count_0) |-> count_0 == $past(count_0) + 16'h0001
      || count_0 == 16'h0000)
    else $error("low count jumped");
  c_low: cover property (match_flag[0]);
  c_joined: cover property (match_flag[1] && timer_a_low_control[3]);
  c_odd_b: cover property (match_flag[3]);
endmodule
bind paired_timer_32bit paired_timer_properties paired_timer_properties_i (
  .clock, .arst_n, .timer_a_low_control, .timer_b_low_control, .count_0,
  .count_1, .match_flag, .dma_request, .capture_timebase_tick, .adc_trigger
);

//--- verification/paired_timer_32bit_test.sv
// Self-checking bench for the paired timer block.
`timescale 1ns/100ps
module paired_timer_32bit_test;
  import paired_timer_pkg::*;
  logic clock = 0, arst_n = 0, ext_en = 0, pulse, adc;
  word_t ctl[4] = '{default: 16'h0000};
  word_t pd = 16'h0000, c0, c1, c2, c3;
  logic [3:0] pl = 4'h0, gate = 4'h0, mf, dma;
  logic [1:0] cap;
  int miscompares = 0, comparisons = 0;
  always #12.5 clock = ~clock;
  ext_pulser ext_pulser_i (.clock(clock), .en(ext_en), .pulse(pulse));
  paired_timer_32bit paired_timer_32bit_i (.clock(clock), .arst_n(arst_n),
    .timer_a_low_control(ctl[0]), .timer_a_high_control(ctl[1]),
    .timer_b_low_control(ctl[2]), .timer_b_high_control(ctl[3]),
    .period_load(pl), .period_data(pd), .ext_clk({pulse, 3'h0}),
    .gate_in(gate), .count_0(c0), .count_1(c1), .count_2(c2),
    .count_3(c3), .match_flag(mf), .dma_request(dma),
    .capture_timebase_tick(cap), .adc_trigger(adc));
  // ---------------------------
  // Tasks
  // ---------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_mf(input int b, input int lim);
    int n;
    n = 0;
    while (mf[b] !== 1'b1) begin
      tick(1);
      n++;
      if (n > lim) begin
        miscompares++;
        final_report();
      end
    end
  endtask
  task automatic load(input int t, input word_t v);
    @(negedge clock);
    pd = v;
    pl[t] = 1'b1;
    @(negedge clock);
    pl = 4'h0;
  endtask
  task automatic walk_wrap;
    load(0, 16'h0002);
    ctl[0] = 16'h8000;
    wait_mf(0, 10);
    chk(c0, 16'h0000);
    tick(1);
    chk({c0[14:0], mf[0]}, 16'h0002);
    tick(1);
    chk(c0, 16'h0002);
    tick(1);
    chk({c0[14:0], mf[0]}, 16'h0001);
  endtask
  task automatic joined_pair;
    @(negedge clock);
    ctl[0] = 16'h0000;
    load(1, 16'h0001);
    load(0, 16'h0000);
    ctl[0] = 16'h8008;
    wait_mf(1, 70000);
    chk({c1, c0}, 32'h00000000);
    chk({adc, mf[0]}, 32'h00000002);
  endtask
  task automatic ext_split;
    load(3, 16'h0002);
    ctl[3] = 16'h8002;
    ext_en = 1'b1;
    wait_mf(3, 100);
    chk({adc, cap, c3}, 32'h00040000);
    @(negedge clock);
    ext_en = 1'b0;
  endtask
  task automatic gated;
    @(negedge clock);
    ctl[2] = 16'h8040;
    gate[2] = 1'b1;
    repeat (5) @(negedge clock);
    gate[2] = 1'b0;
    tick(4);
    chk(c2, 16'h0005);
  endtask
  task automatic joined_b_prescaled;
    load(3, 16'h0000);
    load(2, 16'h0008);
    ctl[2] = 16'h8018;
    tick(4);
    chk(c2, 16'h0005);
    wait_mf(3, 40);
    chk({c3, c2}, 32'h00000000);
    chk({adc, mf[2]}, 32'h00000002);
  endtask
  initial begin
    repeat (8) @(negedge clock);
    arst_n = 1'b1;
    walk_wrap();
    joined_pair();
    ext_split();
    gated();
    joined_b_prescaled();
    final_report();
  end
endmodule
